// >>> wspdf_framer.v
`timescale 1ns/1ns
`include "wspdf_consts.vh"
module wspdf_framer (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Link side, from the frame receiver
  input  wire        i_link_active,
  input  wire        i_cycle_start,
  input  wire        i_od_req,
  input  wire [7:0]  i_pdout_byte,
  input  wire        i_pdout_valid,
  input  wire        i_tx_ready,
  // Link side, to the transmitter
  output wire        o_tx_valid,
  output reg  [7:0]  o_tx_byte,
  output reg         o_tx_last,
  // On-demand data source
  input  wire [15:0] i_od_word,
  input  wire        i_od_word_valid,
  // Measurement and status
  input  wire [31:0] i_weight,
  input  wire        i_gross_net_flag,
  input  wire        i_motion_flag,
  input  wire        i_centre_zero_flag,
  input  wire        i_preset_tare_flag,
  input  wire        i_zero_range_flag,
  input  wire        i_zeroing_done_flag,
  input  wire [1:0]  i_weighing_range_field,
  input  wire [1:0]  i_limit_status_field,
  input  wire [1:0]  i_app_mode,
  input  wire        i_dio_state,
  input  wire        i_trig_settle,
  input  wire        i_trig_meas,
  input  wire        i_trig_result_new,
  input  wire        i_coarse_flow,
  input  wire        i_fine_flow,
  input  wire        i_fill_result_new,
  input  wire        i_switch_signal_one,
  input  wire        i_switch_signal_two,
  // Event causes and acknowledge
  input  wire        i_evt_load,
  input  wire        i_evt_temp,
  input  wire        i_evt_osc,
  input  wire        i_evt_ack,
  // Status and master outputs
  output wire [2:0]  o_evt_causes,
  output wire        o_evt_pending,
  output reg         o_zero_set_req,
  output reg         o_sensor_control_bit,
  output reg         o_frame_done,
  // Shared data/switching pin
  output reg         o_cq_sio_out,
  output reg         o_cq_sio_oe
);

  ////////////////////////////////////////////////////////////////
  // States
  localparam [1:0] ST_IDLE = 2'h0;  // Waiting for a cycle
  localparam [1:0] ST_OD   = 2'h1;  // On-demand bytes
  localparam [1:0] ST_PD   = 2'h2;  // Process input bytes
  localparam [1:0] ST_CKS  = 2'h3;  // Checksum/status byte

  reg  [1:0]  state_q;        // Frame state
  reg  [1:0]  state_d;
  reg  [2:0]  idx_q;          // Byte index within a section
  reg  [2:0]  idx_d;
  reg  [47:0] frame_img_q;    // Image frozen per cycle
  reg  [15:0] od_q;           // On-demand word for this cycle
  reg  [7:0]  chk_q;          // Running XOR of sent bytes
  reg  [7:0]  cur_byte;       // Byte to present from the next edge on
  reg  [15:0] od_nxt;         // On-demand word as it will be held
  reg  [47:0] img_nxt;        // Image as it will be held
  reg  [7:0]  chk_nxt;        // XOR as it will be held
  reg         link_s1_q;      // Pin-side sync stage one
  reg         link_s2_q;      // Synced link state
  wire [47:0] image;
  wire [2:0]  evt_causes;
  wire        evt_pending;
  wire        fire;
  wire        start;          // Idle to first on-demand byte
  wire        od_take;        // Master asked and a word is ready

  assign fire         = o_tx_valid & i_tx_ready;
  assign start        = (state_q == ST_IDLE) && (state_d == ST_OD);
  assign od_take      = i_od_req & i_od_word_valid;
  assign o_tx_valid   = (state_q != ST_IDLE);
  assign o_evt_causes = evt_causes;
  assign o_evt_pending = evt_pending;

  // Returns byte n of the input image, PDin0 = most significant
  function [7:0] img_byte;
    input [47:0] img;
    input [2:0]  n;
    begin
      case (n)
        3'h0:    img_byte = img[47:40];
        3'h1:    img_byte = img[39:32];
        3'h2:    img_byte = img[31:24];
        3'h3:    img_byte = img[23:16];
        3'h4:    img_byte = img[15:8];
        default: img_byte = img[7:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Field packing
  wspdf_status_pack u_pack (
    .i_clk                  (i_clk),
    .i_sys_rst              (i_sys_rst),
    .i_weight               (i_weight),
    .i_gross_net_flag       (i_gross_net_flag),
    .i_motion_flag          (i_motion_flag),
    .i_centre_zero_flag     (i_centre_zero_flag),
    .i_preset_tare_flag     (i_preset_tare_flag),
    .i_zero_range_flag      (i_zero_range_flag),
    .i_zeroing_done_flag    (i_zeroing_done_flag),
    .i_weighing_range_field (i_weighing_range_field),
    .i_limit_status_field   (i_limit_status_field),
    .i_app_mode             (i_app_mode),
    .i_dio_state            (i_dio_state),
    .i_trig_settle          (i_trig_settle),
    .i_trig_meas            (i_trig_meas),
    .i_trig_result_new      (i_trig_result_new),
    .i_coarse_flow          (i_coarse_flow),
    .i_fine_flow            (i_fine_flow),
    .i_fill_result_new      (i_fill_result_new),
    .i_switch_signal_one    (i_switch_signal_one),
    .i_switch_signal_two    (i_switch_signal_two),
    .o_image                (image)
  );

  // Event causes
  wspdf_event_latch #(
    .W (`WSPDF_EVT_W)
  ) u_evt (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_cause   ({i_evt_osc, i_evt_temp, i_evt_load}),
    .i_ack     (i_evt_ack),
    .o_causes  (evt_causes),
    .o_pending (evt_pending)
  );

  ////////////////////////////////////////////////////////////////
  // Link presence comes from the pin, so synchronise it
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
    end else begin
      link_s1_q <= i_link_active;
      link_s2_q <= link_s1_q;
    end
  end

  // Pin fallback: switching output when no master talks
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cq_sio_out <= 1'b0;
      o_cq_sio_oe  <= 1'b0;
    end else begin
      o_cq_sio_oe  <= ~link_s2_q;
      o_cq_sio_out <= link_s2_q ? 1'b0 : i_switch_signal_one;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Byte selection for the next edge; the output register then
  // shows the byte of the state it enters, with no extra lag
  always @* begin
    od_nxt  = start ? (od_take ? i_od_word : 16'h0) : od_q;
    img_nxt = start ? image : frame_img_q;
    chk_nxt = start ? 8'h0 : (fire ? (chk_q ^ o_tx_byte) : chk_q);
    case (state_d)
      ST_OD: begin
        // Idle on-demand bytes are zero when nothing was asked
        cur_byte = idx_d[0] ? od_nxt[7:0] : od_nxt[15:8];
      end
      ST_PD: begin
        cur_byte = img_byte(img_nxt, idx_d);
      end
      ST_CKS: begin
        cur_byte = chk_nxt;
        cur_byte[`WSPDF_CKS_EVENT_BIT] = evt_pending;
      end
      default: begin
        cur_byte = 8'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Frame sequencer: OD0, OD1, PDin0..5, CKS
  always @* begin
    state_d = state_q;
    idx_d   = idx_q;
    case (state_q)
      ST_IDLE: begin
        if (i_cycle_start && link_s2_q) begin
          state_d = ST_OD;
          idx_d   = 3'h0;
        end
      end
      ST_OD: begin
        if (fire) begin
          if (idx_q == 3'h1) begin
            state_d = ST_PD;
            idx_d   = 3'h0;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      ST_PD: begin
        if (fire) begin
          if (idx_q == 3'h5) begin
            state_d = ST_CKS;
            idx_d   = 3'h0;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      ST_CKS: begin
        if (fire) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Link loss aborts the frame
    if (!link_s2_q) begin
      state_d = ST_IDLE;
      idx_d   = 3'h0;
    end
  end

  // Sequencer registers and per-cycle snapshot
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q      <= ST_IDLE;
      idx_q        <= 3'h0;
      frame_img_q  <= 48'h0;
      od_q         <= 16'h0;
      chk_q        <= 8'h0;
      o_tx_byte    <= 8'h0;
      o_tx_last    <= 1'b0;
      o_frame_done <= 1'b0;
    end else begin
      state_q      <= state_d;
      idx_q        <= idx_d;
      o_frame_done <= fire && (state_q == ST_CKS);
      // Image frozen at cycle start so all six bytes are coherent
      frame_img_q  <= img_nxt;
      od_q         <= od_nxt;
      chk_q        <= chk_nxt;
      o_tx_byte    <= cur_byte;
      o_tx_last    <= (state_d == ST_CKS);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Master output byte decode
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_zero_set_req       <= 1'b0;
      o_sensor_control_bit <= 1'b0;
    end else if (!link_s2_q) begin
      o_zero_set_req       <= 1'b0;
    end else if (i_pdout_valid) begin
      o_zero_set_req       <= i_pdout_byte[`WSPDF_ZERO_SET_BIT];
      o_sensor_control_bit <= i_pdout_byte[`WSPDF_SENSOR_CTRL_BIT];
    end
  end

endmodule // wspdf_framer

// >>> wspdf_consts.vh
`ifndef WSPDF_CONSTS_VH
`define WSPDF_CONSTS_VH
// Input image layout, 48 bits, bit 47 sent first
`define WSPDF_PDIN_BYTES      6
`define WSPDF_PDIN_BITS       48
`define WSPDF_WEIGHT_OFS      16
`define WSPDF_WEIGHT_W        32
`define WSPDF_GROSS_NET_BIT   15
`define WSPDF_MOTION_BIT      14
`define WSPDF_CENTRE_ZERO_BIT 13
`define WSPDF_PRESET_TARE_BIT 12
`define WSPDF_ZERO_RANGE_BIT  11
`define WSPDF_ZERO_DONE_BIT   10
`define WSPDF_RANGE_OFS       8
`define WSPDF_LIMIT_OFS       6
`define WSPDF_APP1_BIT        5
`define WSPDF_APP2_BIT        4
`define WSPDF_APP3_BIT        3
`define WSPDF_UNUSED_BIT      2
`define WSPDF_SWITCH2_BIT     1
`define WSPDF_SWITCH1_BIT     0
// Output byte layout
`define WSPDF_ZERO_SET_BIT    4
`define WSPDF_SENSOR_CTRL_BIT 0
// Event flag position in checksum/status byte
`define WSPDF_CKS_EVENT_BIT   7
// Application modes
`define WSPDF_APP_STANDARD    2'h0
`define WSPDF_APP_TRIGGER     2'h1
`define WSPDF_APP_FILLING     2'h2
// Event cause bit positions
`define WSPDF_EVT_LOAD        0
`define WSPDF_EVT_TEMP        1
`define WSPDF_EVT_OSC         2
`define WSPDF_EVT_W           3
`endif

// >>> wspdf_status_pack.v
`timescale 1ns/1ns
`include "wspdf_consts.vh"
// Packs the weight and status fields into the 48-bit input image
module wspdf_status_pack (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Measurement inputs
  input  wire [31:0] i_weight,
  input  wire        i_gross_net_flag,
  input  wire        i_motion_flag,
  input  wire        i_centre_zero_flag,
  input  wire        i_preset_tare_flag,
  input  wire        i_zero_range_flag,
  input  wire        i_zeroing_done_flag,
  input  wire [1:0]  i_weighing_range_field,
  input  wire [1:0]  i_limit_status_field,
  input  wire [1:0]  i_app_mode,
  input  wire        i_dio_state,
  input  wire        i_trig_settle,
  input  wire        i_trig_meas,
  input  wire        i_trig_result_new,
  input  wire        i_coarse_flow,
  input  wire        i_fine_flow,
  input  wire        i_fill_result_new,
  input  wire        i_switch_signal_one,
  input  wire        i_switch_signal_two,
  // Packed image
  output reg  [47:0] o_image
);

  reg        trig_toggle_q;  // Toggles per trigger result
  reg        app1;           // Mode dependent flag values
  reg        app2;
  reg        app3;
  reg [47:0] image_d;

  ////////////////////////////////////////////////////////////////
  // Trigger result toggle, held so the master sees every result
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      trig_toggle_q <= 1'b0;
    end else if (i_trig_result_new) begin
      trig_toggle_q <= ~trig_toggle_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Application flag selection by mode
  always @* begin
    case (i_app_mode)
      `WSPDF_APP_TRIGGER: begin
        app1 = i_trig_settle;
        app2 = i_trig_meas;
        app3 = trig_toggle_q;
      end
      `WSPDF_APP_FILLING: begin
        app1 = i_coarse_flow;
        app2 = i_fine_flow;
        app3 = i_fill_result_new;
      end
      default: begin
        // Standard mode: pin state, others unused
        app1 = i_dio_state;
        app2 = 1'b0;
        app3 = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Field placement
  always @* begin
    image_d = 48'h0;
    image_d[`WSPDF_WEIGHT_OFS +: `WSPDF_WEIGHT_W] = i_weight;
    image_d[`WSPDF_GROSS_NET_BIT]   = i_gross_net_flag;
    image_d[`WSPDF_MOTION_BIT]      = i_motion_flag;
    image_d[`WSPDF_CENTRE_ZERO_BIT] = i_centre_zero_flag;
    image_d[`WSPDF_PRESET_TARE_BIT] = i_preset_tare_flag;
    image_d[`WSPDF_ZERO_RANGE_BIT]  = i_zero_range_flag;
    image_d[`WSPDF_ZERO_DONE_BIT]   = i_zeroing_done_flag;
    image_d[`WSPDF_RANGE_OFS +: 2]  = i_weighing_range_field;
    image_d[`WSPDF_LIMIT_OFS +: 2]  = i_limit_status_field;
    image_d[`WSPDF_APP1_BIT]        = app1;
    image_d[`WSPDF_APP2_BIT]        = app2;
    image_d[`WSPDF_APP3_BIT]        = app3;
    image_d[`WSPDF_UNUSED_BIT]      = 1'b0;
    image_d[`WSPDF_SWITCH2_BIT]     = i_switch_signal_two;
    image_d[`WSPDF_SWITCH1_BIT]     = i_switch_signal_one;
  end

  // Registered image for a clean data output
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_image <= 48'h0;
    end else begin
      o_image <= image_d;
    end
  end

endmodule // wspdf_status_pack

// >>> wspdf_event_latch.v
`timescale 1ns/1ns
`include "wspdf_consts.vh"
// Sticky event causes; a new cause beats a simultaneous acknowledge
module wspdf_event_latch #(
  parameter W = `WSPDF_EVT_W
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // Cause levels and acknowledge
  input  wire [W-1:0] i_cause,
  input  wire         i_ack,
  // Latched causes and summary
  output reg  [W-1:0] o_causes,
  output wire         o_pending
);

  reg  [W-1:0] cause_prev_q;  // For rising edge detect
  wire [W-1:0] cause_rise;

  assign cause_rise = i_cause & ~cause_prev_q;
  assign o_pending  = |o_causes;

  ////////////////////////////////////////////////////////////////
  // Per-cause sticky flag, set wins over clear
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_evt
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_causes[g]     <= 1'b0;
          cause_prev_q[g] <= 1'b0;
        end else begin
          cause_prev_q[g] <= i_cause[g];
          if (cause_rise[g]) begin
            o_causes[g] <= 1'b1;
          end else if (i_ack) begin
            o_causes[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // wspdf_event_latch

// >>> wspdf_master_model.sv
`timescale 1ns/1ns
// Transmitter side of the master link: accepts reply bytes, stalls at random
module wspdf_master_model (
  // Clock and stall mode
  input  wire i_clk,
  input  wire i_slow,
  // Byte acceptance
  output reg  o_ready
);
  integer s = 32'h3e0216cc; // Own seed, so stalls do not shift bench values

  ////////////////////////////////////////////////////////////////////////////
  // Ready moves just after the edge; a slow master stalls any byte
  initial begin
    o_ready = 1'b1;
    forever begin
      @(posedge i_clk);
      #1 o_ready = i_slow ? (($random(s) & 32'h1) != 0) : 1'b1;
    end
  end
endmodule // wspdf_master_model

// >>> wspdf_framer_checker.sv
`timescale 1ns/1ns
// Port-level relations of the framer
module wspdf_framer_checker (
  // Clock and reset
  input wire       i_clk,
  input wire       i_sys_rst,
  // Inputs watched
  input wire       i_link_active,
  input wire       i_tx_ready,
  input wire [7:0] i_pdout_byte,
  input wire       i_pdout_valid,
  input wire       i_switch_signal_one,
  input wire       i_evt_load,
  input wire       i_evt_temp,
  input wire       i_evt_osc,
  input wire       i_evt_ack,
  // Outputs watched
  input wire       o_tx_valid,
  input wire [2:0] o_evt_causes,
  input wire       o_evt_pending,
  input wire       o_zero_set_req,
  input wire       o_sensor_control_bit,
  input wire       o_frame_done,
  input wire       o_cq_sio_out,
  input wire       o_cq_sio_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing
  done_after_frame_a: assert property (o_frame_done |-> !o_tx_valid && $past(o_tx_valid))
    else $error("frame done without a frame");
  done_one_cycle_a: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done too long");
  // The link flag acts two edges late, so the raw pin two edges back is what counts
  stall_hold_a: assert property (o_tx_valid && !i_tx_ready && $past(i_link_active, 2)
    |=> o_tx_valid)
    else $error("reply dropped during stall");
  // Sync delay of the link flag is covered by four idle cycles
  no_link_idle_a: assert property (!i_link_active [*4] |=> !o_tx_valid)
    else $error("data sent without link");
  no_link_oe_a: assert property (!i_link_active [*4] |=> o_cq_sio_oe)
    else $error("pin not switching output");
  sio_follow_a: assert property ($stable(i_switch_signal_one) [*3] ##0 o_cq_sio_oe
    |-> o_cq_sio_out == i_switch_signal_one)
    else $error("pin level wrong");
  // Master byte fields
  zero_set_a: assert property (i_pdout_valid |=> o_zero_set_req == $past(i_pdout_byte[4]))
    else $error("zero set bit wrong");
  ctrl_bit_a: assert property (i_pdout_valid |=> o_sensor_control_bit == $past(i_pdout_byte[0]))
    else $error("control bit wrong");
  // Events
  load_set_a: assert property ($rose(i_evt_load) |-> ##[1:2] o_evt_causes[0])
    else $error("load cause not latched");
  pend_or_a: assert property (o_evt_pending == |o_evt_causes)
    else $error("pending flag wrong");
  ack_clear_a: assert property (i_evt_ack && !$rose(i_evt_load) && !$rose(i_evt_temp)
    && !$rose(i_evt_osc) |=> o_evt_causes == 3'h0)
    else $error("causes not cleared");

  c_frame: cover property (o_frame_done);
  c_pend: cover property (o_evt_pending ##1 i_evt_ack);
  c_sio: cover property (o_cq_sio_oe && o_cq_sio_out);
endmodule // wspdf_framer_checker

bind wspdf_framer wspdf_framer_checker i_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_active(i_link_active),
  .i_tx_ready(i_tx_ready), .i_pdout_byte(i_pdout_byte), .i_pdout_valid(i_pdout_valid),
  .i_switch_signal_one(i_switch_signal_one), .i_evt_load(i_evt_load),
  .i_evt_temp(i_evt_temp), .i_evt_osc(i_evt_osc), .i_evt_ack(i_evt_ack),
  .o_tx_valid(o_tx_valid), .o_evt_causes(o_evt_causes), .o_evt_pending(o_evt_pending),
  .o_zero_set_req(o_zero_set_req), .o_sensor_control_bit(o_sensor_control_bit),
  .o_frame_done(o_frame_done), .o_cq_sio_out(o_cq_sio_out), .o_cq_sio_oe(o_cq_sio_oe));

// >>> weigh_sensor_process_data_framer_tb.sv
`timescale 1ns/1ns
module weigh_sensor_process_data_framer_tb;
  reg         i_clk, i_sys_rst, lnk, cs, odq, pv, ack, trn, slow, tgl;
  reg  [7:0]  pb;
  reg  [15:0] odw, f; // Flag bundle, one bit per status input
  reg  [31:0] w;
  reg  [1:0]  rng, lim, md;
  reg  [2:0]  cz, ev; // Cause levels and expected latched causes
  wire        rdy, tv, tl, done, zs, sc, pend, so, soe;
  wire [7:0]  tb_o;
  wire [2:0]  cc;
  integer     seed, n_mismatch, num_checks, n;

  wspdf_framer i_wspdf_framer (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_link_active(lnk), .i_cycle_start(cs), .i_od_req(odq), .i_pdout_byte(pb),
    .i_pdout_valid(pv), .i_tx_ready(rdy), .o_tx_valid(tv), .o_tx_byte(tb_o),
    .o_tx_last(tl), .i_od_word(odw), .i_od_word_valid(odq), .i_weight(w),
    .i_gross_net_flag(f[0]), .i_motion_flag(f[1]), .i_centre_zero_flag(f[2]),
    .i_preset_tare_flag(f[3]), .i_zero_range_flag(f[4]), .i_zeroing_done_flag(f[5]),
    .i_weighing_range_field(rng), .i_limit_status_field(lim), .i_app_mode(md),
    .i_dio_state(f[6]), .i_trig_settle(f[7]), .i_trig_meas(f[8]),
    .i_trig_result_new(trn), .i_coarse_flow(f[9]), .i_fine_flow(f[10]),
    .i_fill_result_new(f[11]), .i_switch_signal_one(f[12]), .i_switch_signal_two(f[13]),
    .i_evt_load(cz[0]), .i_evt_temp(cz[1]), .i_evt_osc(cz[2]), .i_evt_ack(ack),
    .o_evt_causes(cc), .o_evt_pending(pend), .o_zero_set_req(zs),
    .o_sensor_control_bit(sc), .o_frame_done(done), .o_cq_sio_out(so), .o_cq_sio_oe(soe));
  wspdf_master_model i_wspdf_master_model (.i_clk(i_clk), .i_slow(slow), .o_ready(rdy));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report helpers
  task chk_byte(input [7:0] g, input [7:0] e);
    begin
      num_checks++;
      if (g !== e) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_bit(input g, input e);
    begin
      num_checks++;
      if (g !== e) begin
        n_mismatch++;
        $display("wrong value at %0t: bit got %b expected %b", $time, g, e);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge i_clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference image built from the field layout
  function automatic [47:0] img();
    reg a1, a2, a3;
    begin
      a1 = md == 2'h0 ? f[6] : md == 2'h1 ? f[7] : f[9];
      a2 = md == 2'h0 ? 1'b0 : md == 2'h1 ? f[8] : f[10];
      a3 = md == 2'h0 ? 1'b0 : md == 2'h1 ? tgl : f[11];
      img = {w, f[0], f[1], f[2], f[3], f[4], f[5], rng, lim, a1, a2, a3, 1'b0, f[13], f[12]};
    end
  endfunction

  // One reply frame; dbl holds start high into the busy frame, which must be ignored
  task frame(input reg dbl);
    reg [47:0] m;
    reg [7:0]  e [0:8];
    reg [7:0]  x;
    integer    k, t;
    begin
      m = img();
      e[0] = odq ? odw[15:8] : 8'h00;
      e[1] = odq ? odw[7:0] : 8'h00;
      for (k = 0; k < 6; k++) e[k+2] = m[47-8*k -: 8];
      x = 8'h00;
      for (k = 0; k < 8; k++) x = x ^ e[k];
      e[8] = {|ev, x[6:0]};
      cs = 1'b1;
      fork
        begin
          repeat (dbl ? 3 : 1) tick;
          cs = 1'b0;
        end
      join_none
      k = 0;
      t = 0;
      while (k < 9 && t < 300) begin
        @(negedge i_clk);
        t++;
        if (tv === 1'b1 && rdy === 1'b1) begin
          chk_byte(tb_o, e[k]);
          chk_bit(tl, k == 8);
          k++;
        end
      end
      chk_bit(k == 9, 1'b1);
      @(negedge i_clk);
      chk_bit(done, 1'b1);
      chk_bit(tv, 1'b0);
      tick;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h3e0216cc;
    {lnk, cs, odq, pv, ack, trn, slow, tgl, pb, odw, f, w, rng, lim, md, cz, ev} = 0;
    n_mismatch = 0;
    num_checks = 0;
    i_sys_rst = 1'b1;
    lnk = 1'b1;
    repeat (10) tick;
    i_sys_rst = 1'b0;
    repeat (4) tick;
    for (n = 0; n < 9; n++) begin
      {w, odw, f} = {$random(seed), $random(seed)};
      rng = {$random(seed)} % 3;
      lim = $random(seed);
      md = n % 3;
      odq = $random(seed);
      slow = n[0];
      if (md == 2'h1) begin
        trn = 1'b1;
        tick;
        trn = 1'b0;
        tgl = ~tgl;
      end
      repeat (3) tick;
      frame(n == 4);
    end
    // Master output byte, one every second clock
    repeat (4) begin
      pb = $random(seed);
      pv = 1'b1;
      tick;
      pv = 1'b0;
      tick;
      chk_bit(zs, pb[4]);
      chk_bit(sc, pb[0]);
    end
    // Each cause latches, acknowledge clears
    for (n = 0; n < 3; n++) begin
      cz = 3'h1 << n;
      tick;
      cz = 3'h0;
      repeat (2) tick;
      chk_byte(cc, 3'h1 << n);
      chk_bit(pend, 1'b1);
      ev = 3'h1 << n;
      if (n == 2) frame(0);
      ack = 1'b1;
      cz = {1'b0, n == 0, 1'b0}; // Temperature rising beside the ack must win
      tick;
      {ack, cz} = 0;
      repeat (2) tick;
      ev = {1'b0, n == 0, 1'b0};
      chk_byte(cc, ev);
    end
    ack = 1'b1;
    tick;
    ack = 1'b0;
    ev = 3'h0;
    tick;
    chk_byte(cc, 3'h0);
    // Link loss: pin becomes a switching output, starts are refused
    lnk = 1'b0;
    repeat (6) tick;
    chk_bit(soe, 1'b1);
    chk_bit(so, f[12]);
    f[12] = ~f[12];
    cs = 1'b1;
    tick;
    cs = 1'b0;
    repeat (4) tick;
    chk_bit(tv, 1'b0);
    chk_bit(so, f[12]);
    lnk = 1'b1;
    repeat (6) tick;
    chk_bit(soe, 1'b0);
    frame(0);
    give_verdict;
  end

  // Hang guard, well beyond the length of the sequence
  initial begin
    #400000;
    n_mismatch++;
    give_verdict;
  end
endmodule // weigh_sensor_process_data_framer_tb
